// *** src/drp_defs.vh ***
// Purpose: constants for the sample ROM nibble read port
// Assumes: nibble-wide register port of the on-chip 4-bit core
// Notes:   offsets are nibble addresses in the common register block
`ifndef DRP_DEFS_VH
`define DRP_DEFS_VH
`define DRP_REG_AW        5
`define DRP_OFS_ADDR0     5'h18
`define DRP_OFS_ADDR1     5'h19
`define DRP_OFS_ADDR2     5'h1A
`define DRP_OFS_ADDR3     5'h1B
`define DRP_OFS_DATA_LO   5'h1C
`define DRP_OFS_DATA_HI   5'h1D
`define DRP_OFS_ADDR4     5'h1E
`define DRP_ROM_AW        20
`define DRP_ROM_DW        8
`define DRP_END_SMALL     20'hCFFBF
`define DRP_END_LARGE     20'hFFFBF
`define DRP_TDRR_CYCLES   2'd2
`endif

// *** src/drp_rom_port.v ***
// Purpose: sample ROM read port: five address nibbles, two data nibbles
// Assumes: ROM array outside answers rom_data_in one clock after rom_addr_out
// Notes:   address registers hold no reset value; read data is registered
`timescale 1ns/1ps
`default_nettype none
`include "drp_defs.vh"
module drp_rom_port #(
  parameter ROM_AW = `DRP_ROM_AW
) (
  // Clock and reset
  input  wire                     sys_clk_in,
  input  wire                     rst_n_in,
  // Option straps, fixed after programming
  input  wire                     wdt_option_in,
  input  wire                     variant_large_in,
  // Core register port
  input  wire [`DRP_REG_AW-1:0]   reg_addr_in,
  input  wire                     reg_wr_in,
  input  wire                     reg_rd_in,
  input  wire [3:0]               reg_wdata_in,
  output reg  [3:0]               reg_rdata_out,
  output wire                     reg_hit_out,
  // Sample ROM array
  output wire [ROM_AW-1:0]        rom_addr_out,
  input  wire [`DRP_ROM_DW-1:0]   rom_data_in,
  // Status
  output reg                      data_ready_out,
  output reg                      wdt_restart_out,
  output wire [ROM_AW-1:0]        usable_end_out
);

  reg  [3:0]               addr_nib_r [0:4];
  reg  [`DRP_ROM_DW-1:0]   data_r;
  reg  [1:0]               wait_r;
  reg  [1:0]               wait_nxt;
  wire                     addr_wr;
  wire [2:0]               addr_idx;

  function [2:0] nib_index;
    input [`DRP_REG_AW-1:0] a;
    begin
      case (a)
        `DRP_OFS_ADDR0: nib_index = 3'd0;
        `DRP_OFS_ADDR1: nib_index = 3'd1;
        `DRP_OFS_ADDR2: nib_index = 3'd2;
        `DRP_OFS_ADDR3: nib_index = 3'd3;
        `DRP_OFS_ADDR4: nib_index = 3'd4;
        default:        nib_index = 3'd7;
      endcase
    end
  endfunction

  assign addr_idx = nib_index(reg_addr_in);
  assign addr_wr  = reg_wr_in && (addr_idx != 3'd7);
  assign reg_hit_out = (addr_idx != 3'd7) || (reg_addr_in == `DRP_OFS_DATA_LO)
                       || (reg_addr_in == `DRP_OFS_DATA_HI);

  // Address nibbles concatenated, nibble zero lowest
  assign rom_addr_out = {addr_nib_r[4], addr_nib_r[3], addr_nib_r[2],
                         addr_nib_r[1], addr_nib_r[0]};
  // Reserved top range is not blocked in hardware
  assign usable_end_out = variant_large_in ? `DRP_END_LARGE : `DRP_END_SMALL;

  always @(posedge sys_clk_in) begin
    if (addr_wr) begin
      addr_nib_r[addr_idx] <= reg_wdata_in;
    end
  end

  // Array output captured each clock: valid two clocks after an address write
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      data_r <= {`DRP_ROM_DW{1'b0}};
    end else begin
      data_r <= rom_data_in;
    end
  end

  always @* begin
    wait_nxt = wait_r;
    if (addr_wr) begin
      wait_nxt = `DRP_TDRR_CYCLES;
    end else if (wait_r != 2'd0) begin
      wait_nxt = wait_r - 2'd1;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      wait_r          <= 2'd0;
      data_ready_out  <= 1'b0;
      wdt_restart_out <= 1'b0;
      reg_rdata_out   <= 4'h0;
    end else begin
      wait_r         <= wait_nxt;
      data_ready_out <= (wait_nxt == 2'd0);
      // Data high write only kicks the watchdog, and only when wdt_option_in is set; ROM untouched
      wdt_restart_out <= reg_wr_in && wdt_option_in &&
                         (reg_addr_in == `DRP_OFS_DATA_HI);
      if (reg_rd_in) begin
        case (reg_addr_in)
          `DRP_OFS_DATA_LO: reg_rdata_out <= data_r[3:0];
          `DRP_OFS_DATA_HI: reg_rdata_out <= data_r[7:4];
          default: begin
            if (addr_idx != 3'd7) begin
              reg_rdata_out <= addr_nib_r[addr_idx];
            end else begin
              reg_rdata_out <= 4'h0;
            end
          end
        endcase
      end
    end
  end

endmodule // drp_rom_port
`default_nettype wire

// *** verification/drp_rom_model.sv ***
// Purpose: sample ROM array. Assumes: byte is addr[7:0]^addr[19:12]. Notes: one clock latency
`timescale 1ns/1ps
`default_nettype none
module drp_rom_model (input wire sys_clk_in, input wire [19:0] addr_in, output reg [7:0] data_out);
  always @(posedge sys_clk_in) data_out <= addr_in[7:0] ^ addr_in[19:12];
endmodule // drp_rom_model
`default_nettype wire

// *** verification/drp_rom_port_props.sv ***
// Purpose: port checks. Assumes: ROM answers in one clock. Notes: bind follows the module
`timescale 1ns/1ps
`default_nettype none
module drp_rom_port_props (input wire sys_clk_in, rst_n_in, wdt_option_in, variant_large_in,
  reg_wr_in, reg_rd_in, reg_hit_out, data_ready_out, wdt_restart_out, input wire [4:0] reg_addr_in,
  input wire [3:0] reg_wdata_in, reg_rdata_out, input wire [7:0] rom_data_in,
  input wire [19:0] rom_addr_out, usable_end_out);
  wire [4:0] ad = reg_addr_in;
  wire w = reg_wr_in, r = reg_rd_in & data_ready_out, wa = w & (ad[4:2] == 3'h6 | ad == 5'h1E);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  lo_nib_a: assert property (w && ad[4:2] == 3'h6 |=>
    rom_addr_out[$past(ad[1:0]) * 4 +: 4] == $past(reg_wdata_in)) else $error("nibble");
  top_nib_a: assert property (w && ad == 5'h1E |=>
    rom_addr_out[19:16] == $past(reg_wdata_in)) else $error("top nibble");
  data_ready_a: assert property (wa ##1 !wa [*2] |=> data_ready_out) else $error("ready");
  low_data_a: assert property (r && ad == 5'h1C |=>
    reg_rdata_out == $past(rom_data_in[3:0])) else $error("low data");
  high_data_a: assert property (r && ad == 5'h1D |=>
    reg_rdata_out == $past(rom_data_in[7:4])) else $error("high data");
  wdt_pulse_a: assert property (w && ad == 5'h1D |=>
    wdt_restart_out == $past(wdt_option_in)) else $error("watchdog");
  rom_end_a: assert property (usable_end_out == (variant_large_in ? 20'hFFFBF : 20'hCFFBF))
    else $error("end");
  reg_hit_a: assert property (reg_hit_out == (ad >= 5'h18 && ad <= 5'h1E)) else $error("hit");
  cover property (wa);
  cover property (r);
  cover property (wdt_restart_out);
endmodule // drp_rom_port_props
bind drp_rom_port drp_rom_port_props i_drp_rom_port_props (.*);
`default_nettype wire

// *** verification/test_drp_rom_port.sv ***
// Purpose: bench. Assumes: ROM model beside the port. Notes: inputs change at falling edge
`timescale 1ns/1ps
`default_nettype none
module test_drp_rom_port;
  logic sys_clk_in = 0, rst_n_in = 0, wdt_option_in = 0, variant_large_in = 0, reg_wr_in = 0,
    reg_rd_in = 0, reg_hit_out, data_ready_out, wdt_restart_out;
  logic [4:0] reg_addr_in = 0;
  logic [3:0] reg_wdata_in = 0, reg_rdata_out;
  logic [7:0] rom_data_in;
  logic [19:0] rom_addr_out, usable_end_out, a;
  int n_mismatch = 0, checks = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  drp_rom_port i_drp_rom_port (.*);
  drp_rom_model i_drp_rom_model (.sys_clk_in, .addr_in(rom_addr_out), .data_out(rom_data_in));
  task chk(input [19:0] s, e);
    checks++;
    if (s !== e) begin n_mismatch++; $display("mismatch %0t %h %h", $time, s, e); end
  endtask
  task go(input [4:0] ra, input [3:0] d, input [1:0] s);
    {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = {ra, d, s};
    @(negedge sys_clk_in);
  endtask
  task t_rd(input [19:0] x);
    a = x;
    for (int i = 0; i < 5; i++) go(i < 4 ? 5'h18 + i[4:0] : 5'h1E, a[4 * i +: 4], 2'h2);
    chk(rom_addr_out, a);
    chk(data_ready_out, 1'b0);
    go(5'h1F, 4'h0, 2'h1);
    chk(reg_rdata_out, 20'h0);
    chk(reg_hit_out, 1'b0);
    go(5'h1F, 4'h0, 2'h0);
    chk(data_ready_out, 1'b1);
    for (int j = 0; j < 3; j++) begin
      go(j == 1 ? 5'h1D : 5'h1C, 4'h0, 2'h1);
      chk(reg_rdata_out, j == 1 ? a[7:4] ^ a[19:16] : a[3:0] ^ a[15:12]);
    end
    $display("read %h done", x);
  endtask
  task t_wdt;
    for (int o = 0; o < 2; o++) begin
      {wdt_option_in, variant_large_in} = {2{o[0]}};
      go(5'h1D, 4'h3, 2'h2);
      chk(wdt_restart_out, o[0]);
      chk(usable_end_out, o ? 20'hFFFBF : 20'hCFFBF);
    end
    go(5'h1F, 4'h0, 2'h0);
    $display("watchdog done");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge sys_clk_in);
    rst_n_in = 1;
    t_rd(20'hCFFBF);
    t_rd(20'hFFFC5);
    t_wdt;
    report_and_stop;
  end
endmodule // test_drp_rom_port
`default_nettype wire
